/* File: design/spc_pkg.sv */
// spc_pkg: constants, enums and structs of the speech controller register file
// assumes a 100 MHz system clock and a synchronous active-high reset
package spc_pkg;

    // ================================================================
    // clock and timing
    localparam int CLK_HZ          = 100_000_000;
    localparam int SAMPLE_FREQ_HZ  = 6000;
    localparam int SAMPLE_CYC      = CLK_HZ / SAMPLE_FREQ_HZ; // rounds down
    localparam int DEB_SHORT_US    = 400;
    localparam int DEB_SHORT_CYC   = DEB_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int DEB_LONG_MS     = 50;
    localparam int DEB_LONG_CYC    = DEB_LONG_MS * (CLK_HZ / 1000);
    localparam int CARRIER_HZ      = 38000;
    localparam int CARRIER_CYC     = CLK_HZ / CARRIER_HZ;
    localparam int CARRIER_DUTY_PCT = 75;
    localparam int CARRIER_HI_CYC  = CARRIER_CYC * CARRIER_DUTY_PCT / 100;
    localparam int FLASH_CYC       = 12_500_000; // half period of lamp flash

    // ================================================================
    // register reset values and writable-bit masks
    localparam logic [7:0] GPR_RST    = 8'h10;
    localparam logic [7:0] CFG_RST    = 8'h7f;
    localparam logic [7:0] PAGE_RST   = 8'h00;
    localparam logic [7:0] EN_RST     = 8'h7f;
    localparam logic [7:0] HALT_RST   = 8'h7f;
    localparam logic [7:0] CFGA_WMASK = 8'hf4;
    localparam logic [7:0] CFGB_WMASK = 8'h3d;
    localparam logic [7:0] PAGE_WMASK = 8'h1f;

    // ================================================================
    // field positions
    localparam int CFGA_FLASH    = 7;
    localparam int CFGA_LAMP2SEL = 6;
    localparam int CFGA_IRHW     = 5;
    localparam int CFGA_DEBLONG  = 4;
    localparam int CFGA_HALTASEL = 2;
    localparam int CFGB_ALT      = 5;
    localparam int CFGB_SECT1    = 4;
    localparam int CFGB_LAMP2SEC = 3;
    localparam int CFGB_VOLOFF   = 2;
    localparam int CFGB_CARRIER  = 0;
    localparam int HALT_A        = 0;
    localparam int HALT_C        = 2;

    // ================================================================
    // vectoring
    localparam logic [10:0] POI_VEC      = 11'h020;
    localparam logic [10:0] RISE_OFS     = 11'h004;
    localparam logic [10:0] HIGH_BANK    = 11'h008;
    localparam int          LOW_TRIGS    = 4;

    typedef enum logic [3:0]
    {
        SPC_OP_LD   = 4'h0,
        SPC_OP_JPG  = 4'h1,
        SPC_OP_JPR  = 4'h2,
        SPC_OP_END  = 4'h3,
        SPC_OP_MV   = 4'h4,
        SPC_OP_INC  = 4'h5,
        SPC_OP_TX   = 4'h6
    } spc_op_e;

    typedef enum logic [2:0]
    {
        SPC_T_GPR   = 3'h0,
        SPC_T_CFGA  = 3'h1,
        SPC_T_CFGB  = 3'h2,
        SPC_T_PAGE  = 3'h3,
        SPC_T_ENLO  = 3'h4,
        SPC_T_ENHI  = 3'h5,
        SPC_T_HALT  = 3'h6
    } spc_tgt_e;

    typedef enum logic [1:0]
    {
        SPC_C_NONE  = 2'h0,
        SPC_C_LAST  = 2'h1,
        SPC_C_HIGH  = 2'h2,
        SPC_C_LOW   = 2'h3
    } spc_cond_e;

    typedef struct packed
    {
        spc_op_e    op;
        spc_tgt_e   tgt;
        logic [2:0] rn;
        logic [2:0] rm;
        logic [7:0] value;
        spc_cond_e  cond;
        logic [2:0] cond_idx;
    } spc_instr_s;

endpackage

/* File: design/spc_regfile.sv */
// spc_regfile: special register file, trigger vectoring and output pins
// assumes pin inputs synchronous to clk; synthesis engine and ir modulator
// sit outside and talk through the vector, end and tx ports
`timescale 1ns/1ps

// Overview of operation
// - config a bit 7: flash or steady lamps
// - config a bit 6: lamp2 or halt c
// - config a bit 5: hardware ir or halt-c ir
// - config a bit 4: long or short debounce
// - config a bit 2: halt a or busy
// - config b bit 5: alternate or synchronous flash
// - config b bit 4: lamp1 section control
// - config b bit 3: lamp2 from section or halt c
// - config b bit 2: lamp1 volume control off
// - config b bit 0: 75% carrier on hardware ir
// - halt-c ir always has 38 khz carrier
// - page bits 0-4 used, 5-7 reserved
// - page mode decides which page bits count
// - edge enables: falls low nibble, rises high
// - edge enables take effect any time
// - halt bits drive halt pins inverted
// - page mode fixed at build time
// - default 1-page; high vectors need multipage
// - fixed trigger and power-on vectors
// - one instruction per two sample periods
// - conditional instructions need their condition
// - host link over trigs 1-2 and halt-a pin
// - power-on, then triggers lowest index first, jump last
module spc_regfile
    import spc_pkg::*;
#(
    parameter int PAGE_MODE     = 1,
    parameter int INSTR_SAMPLE  = SAMPLE_CYC,
    parameter int DEB_SHORT     = DEB_SHORT_CYC,
    parameter int DEB_LONG      = DEB_LONG_CYC,
    parameter int FLASH_HALF    = FLASH_CYC
)
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        reset_pin_n,
    input  wire logic [7:0]  trig_in,
    input  wire logic        instr_valid,
    input  wire spc_instr_s  instr,
    input  wire logic        last_pass_sts,
    input  wire logic        synth_busy,
    input  wire logic        section_on,
    input  wire logic        volume_hi,
    input  wire logic        ir_hw_data,
    output logic             instr_busy,
    output logic             vec_valid,
    output logic [10:0]      vec_num,
    output logic             end_pulse,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic [7:0]       page_out,
    output logic             lamp1_output,
    output logic             lamp2_or_halt_c_pin,
    output logic             halt_a_or_busy_pin,
    output logic [7:0]       halt_pins_n,
    output logic             infrared_tx_pin
);

    // ================================================================
    // state
    typedef struct packed
    {
        logic [7:0][7:0]  gpr;
        logic [7:0]       cfga;
        logic [7:0]       cfgb;
        logic [7:0]       page;
        logic [7:0]       en_lo;
        logic [7:0]       en_hi;
        logic [7:0]       halt;
        logic [7:0]       trig_lvl;
        logic [7:0][22:0] deb_cnt;
        logic [16:0]      pend;      // bit 0 power-on, 2i+1 fall, 2i+2 rise
        logic             jp_pend;
        logic [10:0]      jp_vec;
        logic [15:0]      slot_cnt;
        logic             slot_phase;
        logic             ipend;
        spc_instr_s       icur;
        logic [23:0]      flash_cnt;
        logic             flash_ph;
        logic [11:0]      car_cnt;
        logic             vec_valid;
        logic [10:0]      vec_num;
        logic             end_pulse;
        logic             tx_valid;
        logic [7:0]       tx_data;
        logic             lamp1;
        logic             pin_c;
        logic             pin_a;
        logic [7:0]       halt_n;
        logic             ir_pin;
    } spc_state_s;

    spc_state_s st_reg;
    spc_state_s st_next;

    // ================================================================
    // helpers
    // reset image: power-on pending so vector 32 goes out first
    function automatic spc_state_s rst_state();
        spc_state_s s;
        s = '0;
        for (int i = 0; i < 8; i++)
        begin
            s.gpr[i] = GPR_RST;
        end
        s.cfga     = CFG_RST;
        s.cfgb     = CFG_RST;
        s.page     = PAGE_RST;
        s.en_lo    = EN_RST;
        s.en_hi    = EN_RST;
        s.halt     = HALT_RST;
        s.trig_lvl = 8'hff;          // inputs idle high
        s.halt_n   = ~HALT_RST;
        s.pin_a    = 1'b1;
        s.pin_c    = 1'b1;
        s.ir_pin   = 1'b1;           // ir pin is active low
        s.pend     = 17'h00001;
        return s;
    endfunction

    // trigger edge to fixed vector
    function automatic logic [10:0] edge_vec(input int idx, input logic rise);
        logic [10:0] v;
        v = (idx < LOW_TRIGS) ? 11'(idx) : 11'(idx - LOW_TRIGS) + HIGH_BANK;
        if (rise)
        begin
            v = v + RISE_OFS;
        end
        return v;
    endfunction

    // label plus working page, masked by the build-time page mode
    function automatic logic [10:0] page_vec(input logic [7:0] g,
                                             input logic [7:0] pg);
        logic [10:0] v;
        case (PAGE_MODE)
            8:       v = {pg[2:0], g};
            16:      v = {pg[3:0], g[6:0]};
            32:      v = {pg[4:0], g[5:0]};
            default: v = {3'h0, g};
        endcase
        return v;
    endfunction

    // ================================================================
    // next state
    always_comb
    begin
        logic        sample_end;
        logic        exec;
        logic        cond_ok;
        logic        new_lvl;
        logic        granted;
        logic        l2;
        logic [7:0]  wval;
        logic [16:0] grant;
        logic [16:0] evt;
        logic [15:0] en_all;
        int          deb_lim;
        sample_end = 1'b0;
        exec       = 1'b0;
        cond_ok    = 1'b0;
        new_lvl    = 1'b0;
        granted    = 1'b0;
        l2         = 1'b0;
        wval       = 8'h00;
        grant      = '0;
        evt        = '0;
        en_all     = 16'h0000;
        deb_lim    = 0;
        st_next    = st_reg;

        // debounce: level flips once the pin differs long enough
        deb_lim = st_reg.cfga[CFGA_DEBLONG] ? DEB_LONG : DEB_SHORT;
        for (int i = 0; i < 8; i++)
        begin
            new_lvl = st_reg.trig_lvl[i];
            if (trig_in[i] == st_reg.trig_lvl[i])
            begin
                st_next.deb_cnt[i] = '0;
            end
            else if (int'(st_reg.deb_cnt[i]) >= deb_lim - 1)
            begin
                st_next.deb_cnt[i] = '0;
                new_lvl = trig_in[i];
            end
            else
            begin
                st_next.deb_cnt[i] = st_reg.deb_cnt[i] + 23'h1;
            end
            st_next.trig_lvl[i] = new_lvl;
        end

        // edges gated by the live enables, so a rewrite applies at once
        en_all = {st_reg.en_hi, st_reg.en_lo};
        for (int i = 0; i < 8; i++)
        begin
            // fall enable at bit i mod 4, rise at 4 + i mod 4 per byte
            evt[2 * i + 1] = st_reg.trig_lvl[i] & ~st_next.trig_lvl[i]
                           & en_all[(i / 4) * 8 + (i % 4)];
            evt[2 * i + 2] = ~st_reg.trig_lvl[i] & st_next.trig_lvl[i]
                           & en_all[(i / 4) * 8 + 4 + (i % 4)];
        end

        // one vector per cycle, lowest pending index wins
        st_next.vec_valid = 1'b0;
        for (int k = 0; k < 17; k++)
        begin
            if (st_reg.pend[k] && !granted)
            begin
                granted  = 1'b1;
                grant[k] = 1'b1;
                st_next.vec_valid = 1'b1;
                st_next.vec_num = (k == 0) ? POI_VEC
                    : edge_vec((k - 1) / 2, ((k - 1) % 2) == 1);
            end
        end
        if (!granted && st_reg.jp_pend)
        begin
            st_next.jp_pend   = 1'b0;
            st_next.vec_valid = 1'b1;
            st_next.vec_num   = st_reg.jp_vec;
        end
        // a new edge in the serviced cycle stays pending
        st_next.pend = (st_reg.pend & ~grant) | evt;

        // instruction slot every two sample periods
        if (int'(st_reg.slot_cnt) >= INSTR_SAMPLE - 1)
        begin
            st_next.slot_cnt   = '0;
            sample_end         = 1'b1;
            st_next.slot_phase = ~st_reg.slot_phase;
        end
        else
        begin
            st_next.slot_cnt = st_reg.slot_cnt + 16'h1;
        end
        exec = sample_end & st_reg.slot_phase & st_reg.ipend;

        if (instr_valid && !st_reg.ipend)
        begin
            st_next.ipend = 1'b1;
            st_next.icur  = instr;
        end

        case (st_reg.icur.cond)
            SPC_C_LAST: cond_ok = last_pass_sts;
            SPC_C_HIGH: cond_ok = st_reg.trig_lvl[st_reg.icur.cond_idx];
            SPC_C_LOW:  cond_ok = ~st_reg.trig_lvl[st_reg.icur.cond_idx];
            default:    cond_ok = 1'b1;
        endcase

        st_next.end_pulse = 1'b0;
        st_next.tx_valid  = 1'b0;
        if (exec)
        begin
            st_next.ipend = 1'b0;
        end
        if (exec && cond_ok)
        begin
            wval = st_reg.icur.value;
            case (st_reg.icur.op)
                SPC_OP_LD:
                begin
                    case (st_reg.icur.tgt)
                        SPC_T_GPR:  st_next.gpr[st_reg.icur.rn] = wval;
                        SPC_T_CFGA: st_next.cfga = (wval & CFGA_WMASK)
                                    | (st_reg.cfga & ~CFGA_WMASK);
                        SPC_T_CFGB: st_next.cfgb = (wval & CFGB_WMASK)
                                    | (st_reg.cfgb & ~CFGB_WMASK);
                        SPC_T_PAGE: st_next.page = wval & PAGE_WMASK;
                        SPC_T_ENLO: st_next.en_lo = wval;
                        SPC_T_ENHI: st_next.en_hi = wval;
                        SPC_T_HALT: st_next.halt  = wval;
                        default:    st_next.halt  = st_reg.halt;
                    endcase
                end
                SPC_OP_JPG:
                begin
                    st_next.jp_pend = 1'b1;
                    st_next.jp_vec  = page_vec(wval, st_reg.page);
                end
                SPC_OP_JPR:
                begin
                    st_next.jp_pend = 1'b1;
                    st_next.jp_vec  = page_vec(st_reg.gpr[st_reg.icur.rn],
                                               st_reg.page);
                end
                SPC_OP_END: st_next.end_pulse = 1'b1;
                SPC_OP_MV:
                    st_next.gpr[st_reg.icur.rn] = st_reg.gpr[st_reg.icur.rm];
                SPC_OP_INC: st_next.gpr[0] = st_reg.gpr[0] + 8'h01;
                SPC_OP_TX:
                begin
                    st_next.tx_valid = 1'b1;
                    st_next.tx_data  = st_reg.gpr[st_reg.icur.rn];
                end
                default: st_next.end_pulse = 1'b0;
            endcase
        end

        // flash and carrier timebases
        if (int'(st_reg.flash_cnt) >= FLASH_HALF - 1)
        begin
            st_next.flash_cnt = '0;
            st_next.flash_ph  = ~st_reg.flash_ph;
        end
        else
        begin
            st_next.flash_cnt = st_reg.flash_cnt + 24'h1;
        end
        if (int'(st_reg.car_cnt) >= CARRIER_CYC - 1)
        begin
            st_next.car_cnt = '0;
        end
        else
        begin
            st_next.car_cnt = st_reg.car_cnt + 12'h1;
        end

        // pin outputs: halt bits through an inverting stage
        st_next.halt_n = ~st_reg.halt;
        st_next.pin_a  = st_reg.cfga[CFGA_HALTASEL]
                       ? ~st_reg.halt[HALT_A] : synth_busy;
        // host link reuses trig 1-2 inputs and this same pin
        st_next.lamp1 = synth_busy
            & (st_reg.cfgb[CFGB_SECT1] ? section_on : 1'b1)
            & (st_reg.cfgb[CFGB_VOLOFF] ? 1'b1 : volume_hi)
            & (st_reg.cfga[CFGA_FLASH] ? st_reg.flash_ph : 1'b1);
        begin
            l2 = st_reg.cfgb[CFGB_LAMP2SEC] ? (synth_busy & section_on)
                                            : st_reg.halt[HALT_C];
            if (st_reg.cfga[CFGA_FLASH])
            begin
                l2 = l2 & (st_reg.cfgb[CFGB_ALT] ? ~st_reg.flash_ph
                                                 : st_reg.flash_ph);
            end
            st_next.pin_c = st_reg.cfga[CFGA_LAMP2SEL]
                          ? l2 : ~st_reg.halt[HALT_C];
        end
        // ir pin is active low
        if (st_reg.cfga[CFGA_IRHW])
        begin
            st_next.ir_pin = ~(ir_hw_data & (st_reg.cfgb[CFGB_CARRIER]
                ? (int'(st_reg.car_cnt) < CARRIER_HI_CYC) : 1'b1));
        end
        else
        begin
            st_next.ir_pin = ~(st_reg.halt[HALT_C]
                & (int'(st_reg.car_cnt) < CARRIER_CYC / 2));
        end

        // reset pin starts power-on initialisation like srst
        if (srst || !reset_pin_n)
        begin
            st_next = rst_state();
        end
    end

    // ================================================================
    // state register
    always_ff @(posedge clk)
    begin
        st_reg <= st_next;
    end

    // ================================================================
    // outputs straight from the state flops
    assign instr_busy          = st_reg.ipend;
    assign vec_valid           = st_reg.vec_valid;
    assign vec_num             = st_reg.vec_num;
    assign end_pulse           = st_reg.end_pulse;
    assign tx_valid            = st_reg.tx_valid;
    assign tx_data             = st_reg.tx_data;
    assign page_out            = st_reg.page;
    assign lamp1_output        = st_reg.lamp1;
    assign lamp2_or_halt_c_pin = st_reg.pin_c;
    assign halt_a_or_busy_pin  = st_reg.pin_a;
    assign halt_pins_n         = st_reg.halt_n;
    assign infrared_tx_pin     = st_reg.ir_pin;

endmodule

/* File: testbench/spc_regfile_properties.sv */
// spc_regfile_properties: port-level checks of the register file
// assumes bind onto spc_regfile; slot bound follows INSTR_SAMPLE
`timescale 1ns/1ps
module spc_regfile_properties
    import spc_pkg::*;
#(
    parameter int INSTR_SAMPLE = 20,
    parameter int PAGE_MODE    = 1
)
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        reset_pin_n,
    input wire logic        instr_valid,
    input wire logic        instr_busy,
    input wire logic        vec_valid,
    input wire logic [10:0] vec_num,
    input wire logic        end_pulse,
    input wire logic        tx_valid,
    input wire logic [7:0]  page_out,
    input wire logic [7:0]  halt_pins_n
);
    // longest wait: offer lands just after a slot
    localparam int SLOT_MAX = 2 * INSTR_SAMPLE + 1;

    // ============================================================
    // clocking and the instruction steps
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst || !reset_pin_n);

    sequence s_take;
        instr_valid && !instr_busy;
    endsequence
    sequence s_done;
        ##[1:SLOT_MAX] !instr_busy;
    endsequence

    // ============================================================
    // assertions
    a_take_busy: assert property (s_take |=> instr_busy)
        else $error("offer taken but busy stayed low");
    a_slot_bound: assert property ($rose(instr_busy) |-> s_done)
        else $error("instruction not done within two periods");
    a_end_slot: assert property (end_pulse |-> $fell(instr_busy))
        else $error("end pulse outside execute slot");
    a_tx_slot: assert property (tx_valid |-> $fell(instr_busy))
        else $error("tx pulse outside execute slot");
    a_page_rsvd: assert property (page_out[7:5] == 3'h0)
        else $error("reserved page bits set");
    a_page_slot: assert property (!$stable(page_out) |-> $past(instr_busy))
        else $error("page changed without instruction");
    a_halt_slot: assert property (!$stable(halt_pins_n) |-> $past(instr_busy, 2))
        else $error("halt pins changed without instruction");
    a_vec_single: assert property (vec_valid |-> (PAGE_MODE != 1 || vec_num[10:8] == 3'h0))
        else $error("high vector in single page mode");
    a_poi_first: assert property ($fell(srst) |-> ##[1:2] (vec_valid && vec_num == POI_VEC))
        else $error("power-on vector missing after reset");
endmodule

bind spc_regfile spc_regfile_properties #(
    .INSTR_SAMPLE (INSTR_SAMPLE),
    .PAGE_MODE    (PAGE_MODE)
) u_props (
    .clk         (clk),
    .srst        (srst),
    .reset_pin_n (reset_pin_n),
    .instr_valid (instr_valid),
    .instr_busy  (instr_busy),
    .vec_valid   (vec_valid),
    .vec_num     (vec_num),
    .end_pulse   (end_pulse),
    .tx_valid    (tx_valid),
    .page_out    (page_out),
    .halt_pins_n (halt_pins_n)
);

/* File: testbench/spc_trig_model.sv */
// spc_trig_model: eight trigger switches with contact bounce
// assumes the bench sets wanted levels; pins idle high (pull-ups)
`timescale 1ns/1ps
module spc_trig_model
(
    input  wire logic       clk,
    input  wire logic [7:0] level_req,
    output logic [7:0]      trig_in
);
    logic [7:0] prev_req = 8'hff;
    logic [7:0] flip     = 8'h00;

    // each change shows new, old, then settles: one bounce
    initial trig_in = 8'hff;
    always @(posedge clk)
    begin
        prev_req <= level_req;
        trig_in  <= (level_req != prev_req) ? level_req : level_req ^ flip;
        flip     <= level_req ^ prev_req;
    end
endmodule

/* File: testbench/testbench.sv */
// testbench: self-checking bench for spc_regfile
// assumes 100 MHz clock; slot, debounce and flash counts shortened
`timescale 1ns/1ps
module testbench
    import spc_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        reset_pin_n = 1'b1;
    logic [7:0]  trig_in;
    logic [7:0]  level_req = 8'hff;
    logic        instr_valid = 1'b0;
    spc_instr_s  instr;
    logic        last_pass_sts;
    logic        synth_busy;
    logic        section_on;
    logic        volume_hi;
    logic        ir_hw_data;
    logic        instr_busy, vec_valid, end_pulse, tx_valid;
    logic        lamp1, lamp2, halt_a, ir_pin;
    logic [10:0] vec_num;
    logic [7:0]  tx_data, page_out, halt_pins_n;
    logic [31:0] rnd = 32'h2932;
    logic [10:0] exp_vec[$];
    logic [7:0]  exp_tx[$];
    int          fails = 0;
    int          checks = 0;
    int          ends = 0;

    spc_regfile #(.INSTR_SAMPLE(20), .DEB_SHORT(4), .DEB_LONG(10),
                  .FLASH_HALF(8), .PAGE_MODE(1)) dut (
        .clk(clk), .srst(srst), .reset_pin_n(reset_pin_n),
        .trig_in(trig_in), .instr_valid(instr_valid), .instr(instr),
        .last_pass_sts(last_pass_sts), .synth_busy(synth_busy),
        .section_on(section_on), .volume_hi(volume_hi),
        .ir_hw_data(ir_hw_data), .instr_busy(instr_busy),
        .vec_valid(vec_valid), .vec_num(vec_num),
        .end_pulse(end_pulse), .tx_valid(tx_valid), .tx_data(tx_data),
        .page_out(page_out), .lamp1_output(lamp1),
        .lamp2_or_halt_c_pin(lamp2), .halt_a_or_busy_pin(halt_a),
        .halt_pins_n(halt_pins_n), .infrared_tx_pin(ir_pin));
    spc_trig_model u_trig (.clk(clk), .level_req(level_req),
                           .trig_in(trig_in));

    // ============================================================
    // helpers
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmpv(logic [10:0] got, logic [10:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t vector %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmpb(logic [7:0] got, logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t byte %h exp %h", $time, got, exp);
        end
    endtask
    // offer once, then hold off until the slot has run it
    task automatic send(spc_op_e op, spc_tgt_e t, logic [2:0] rn,
                        logic [7:0] v, spc_cond_e c, logic [2:0] ci);
        int n;
        n = 0;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= '{op, t, rn, 3'h0, v, c, ci};
        @(posedge clk);
        instr_valid <= 1'b0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (instr_busy !== 1'b0 && n < 100);
        cmpb({7'h0, instr_busy}, 8'h00);
        @(negedge clk);
    endtask
    task automatic ld(spc_tgt_e t, logic [7:0] v);
        send(SPC_OP_LD, t, 3'h0, v, SPC_C_NONE, 3'h0);
    endtask
    // hold trigger i low for low cycles; fv/rv: vectors expected
    task automatic pulse(int i, int low, bit fv, bit rv);
        logic [10:0] f;
        f = 11'(i < 4 ? i : i + 4);
        if (fv)
            exp_vec.push_back(f);
        @(posedge clk);
        level_req[i] <= 1'b0;
        repeat (low) @(posedge clk);
        if (rv)
            exp_vec.push_back(f + 11'h4);
        level_req[i] <= 1'b1;
        repeat (30) @(posedge clk);
    endtask

    // ============================================================
    // clock, random side inputs, watchdog
    initial forever #5 clk = ~clk;
    initial
    begin
        #300_000;
        fails++;
        report_and_stop();
    end

    // result monitor: oldest note against each pulse
    always @(posedge clk)
    begin
        rnd        <= lfsr(rnd);
        section_on <= rnd[3];
        volume_hi  <= rnd[9];
        ir_hw_data <= rnd[17];
        if (vec_valid === 1'b1)
            cmpv(vec_num, exp_vec.size() ? exp_vec.pop_front() : 11'h7ff);
        if (tx_valid === 1'b1)
            cmpb(tx_data, exp_tx.size() ? exp_tx.pop_front() : 8'hxx);
        if (end_pulse === 1'b1)
            ends++;
    end

    // ============================================================
    // main sequence
    initial
    begin
        logic [7:0] v;
        int         lows;
        last_pass_sts <= 1'b0;
        synth_busy    <= 1'b0;
        exp_vec.push_back(POI_VEC);
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (5) @(negedge clk);
        cmpb(halt_pins_n, ~HALT_RST);
        cmpb(page_out, PAGE_RST);
        // defaults: long debounce, trig 4 rise disabled
        pulse(0, 8, 1'b0, 1'b0);
        pulse(3, 30, 1'b1, 1'b0);
        ld(SPC_T_CFGA, 8'h6f);
        pulse(0, 8, 1'b1, 1'b1);
        ld(SPC_T_ENLO, 8'hff);
        ld(SPC_T_ENHI, 8'hff);
        for (int i = 0; i < 8; i++)
            pulse(i, 30, 1'b1, 1'b1);
        // two falls in one cycle: lower input first
        exp_vec.push_back(11'h0);
        exp_vec.push_back(11'h1);
        @(posedge clk);
        level_req[1:0] <= 2'b00;
        repeat (30) @(posedge clk);
        exp_vec.push_back(11'h4);
        exp_vec.push_back(11'h5);
        level_req[1:0] <= 2'b11;
        repeat (30) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            v = rnd[15:8];
            ld(SPC_T_HALT, v);
            @(negedge clk);
            cmpb(halt_pins_n, ~v);
        end
        ld(SPC_T_PAGE, 8'hff);
        cmpb(page_out, 8'h1f);
        // conditions: trig 1 idle high, last-pass low
        ld(SPC_T_HALT, 8'h00);
        send(SPC_OP_LD, SPC_T_HALT, 3'h0, 8'h0f, SPC_C_HIGH, 3'h0);
        send(SPC_OP_LD, SPC_T_HALT, 3'h0, 8'hf0, SPC_C_LOW, 3'h0);
        send(SPC_OP_LD, SPC_T_HALT, 3'h0, 8'h33, SPC_C_LAST, 3'h0);
        @(negedge clk);
        cmpb(halt_pins_n, 8'hf0);
        @(posedge clk);
        last_pass_sts <= 1'b1;
        send(SPC_OP_LD, SPC_T_HALT, 3'h0, 8'h3c, SPC_C_LAST, 3'h0);
        @(negedge clk);
        cmpb(halt_pins_n, 8'hc3);
        // shared pin shows busy: must follow synth_busy
        ld(SPC_T_CFGA, 8'h6b);
        repeat (3) @(negedge clk);
        v = {7'h0, halt_a};
        @(posedge clk);
        synth_busy <= 1'b1;
        repeat (3) @(negedge clk);
        cmpb({7'h0, halt_a}, v ^ 8'h01);
        send(SPC_OP_LD, SPC_T_GPR, 3'h3, 8'h5a, SPC_C_NONE, 3'h0);
        exp_tx.push_back(8'h5a);
        send(SPC_OP_TX, SPC_T_GPR, 3'h3, 8'h00, SPC_C_NONE, 3'h0);
        exp_vec.push_back(11'h09a);
        send(SPC_OP_JPG, SPC_T_GPR, 3'h0, 8'h9a, SPC_C_NONE, 3'h0);
        send(SPC_OP_END, SPC_T_GPR, 3'h0, 8'h00, SPC_C_NONE, 3'h0);
        repeat (5) @(negedge clk);
        cmpv(11'(ends), 11'h1);
        // steady lamps, halt-c ir carrier
        ld(SPC_T_CFGB, 8'h04);
        ld(SPC_T_CFGA, 8'h4b);
        ld(SPC_T_HALT, 8'h00);
        cmpb({5'h0, lamp1, lamp2, ir_pin}, 8'h05);
        ld(SPC_T_HALT, 8'h04);
        lows = 0;
        repeat (CARRIER_CYC) @(negedge clk) lows += int'(!ir_pin);
        cmpv(11'(lows), 11'(CARRIER_CYC / 2));
        cmpb({6'h0, lamp1, lamp2}, 8'h03);
        // reset pin restarts power-on init
        exp_vec.push_back(POI_VEC);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (5) @(negedge clk);
        cmpb(halt_pins_n, ~HALT_RST);
        cmpb(page_out, PAGE_RST);
        cmpv(11'(exp_vec.size() + exp_tx.size()), 11'h0);
        report_and_stop();
    end
endmodule
